// ### hw/arsp_regs.svh
// Register offsets, field positions, reset values and timing counts of the result port
`ifndef ARSP_REGS_SVH
`define ARSP_REGS_SVH
`define ARSP_CTRL_OFS 8'h00
`define ARSP_STATUS_OFS 8'h04
`define ARSP_RESULT_OFS 8'h08
`define ARSP_CTRL_RST 32'h0000_0000
`define ARSP_CTRL_SER_BIT 0
`define ARSP_CTRL_FMT_BIT 1
`define ARSP_PIN_DIV_LO 2
`define ARSP_PIN_CLKSRC 4
`define ARSP_PIN_POL 5
`define ARSP_PIN_INV 6
`define ARSP_PIN_RDC 7
`define ARSP_PIN_SDO 8
`define ARSP_PIN_SCLK 9
`define ARSP_PIN_FRAME 10
`define ARSP_RESULT_BITS 16
`define ARSP_CLK_NS 50
`define ARSP_QTR_RAC_NS 50
`define ARSP_QTR_RDC_NS 100
`define ARSP_QTR_RAC_CYC ((`ARSP_QTR_RAC_NS + `ARSP_CLK_NS - 1) / `ARSP_CLK_NS)
`define ARSP_QTR_RDC_CYC ((`ARSP_QTR_RDC_NS + `ARSP_CLK_NS - 1) / `ARSP_CLK_NS)
`define ARSP_RESP_OKAY 2'h0
`define ARSP_RESP_SLVERR 2'h2
`endif

// ### hw/arsp_pkg.sv
// Types of the result port
package arsp_pkg;
	typedef enum logic [1:0] {
		ARSP_IDLE = 2'b00,
		ARSP_MASTER = 2'b01,
		ARSP_SLAVE = 2'b10
	} arsp_state_t;
endpackage : arsp_pkg

// ### hw/arsp_port.sv
// Result output port: parallel bus or serial link, with AXI4-Lite control
//
// Notes on behaviour
// - parallel selected: shared pins carry parallel bits 2 to 10.
// - master read-during-convert shifts previous result during conversion, other clock period.
// - master read-after-convert starts shifting only once conversion finished.
// - slave mode: chain input reaches serial output after 16 clock periods.
// - result held in shift register, shifted out MSB first.
// - output coding follows the code format select.
// - master mode: each output bit stable across both shift clock edges.
// - slave, no inversion: update on rising edge, host samples falling.
// - slave, inversion: update on falling edge, host samples rising.
// - shift clock pin output in master, input in slave; inversion picks edge.
// - master, polarity low: frame marker high while data valid.
// - master, polarity high: frame marker low while data valid.
// - port selector low picks parallel bus, high picks serial functions.
// - clock source high: slave, host clock gated by chip select.
// - divider pins slow master clock in read-after-convert, else high impedance.
`timescale 1ns/1ps
`include "arsp_regs.svh"
module arsp_port
	import arsp_pkg::*;
#(
	parameter int W = `ARSP_RESULT_BITS
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [W-1:0] i_result_data,
	input wire logic i_result_valid,
	output logic o_result_ready,
	input wire logic i_conv_busy,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_pin,
	output logic [W-1:0] o_pin_oe
);
	// ==========================================================
	// Pin synchronisers
	logic [W-1:0] pin_s1, pin_s2;
	logic sclk_s3, sel_s1, sel_s2;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			sclk_s3 <= 1'b0;
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
		end else begin
			pin_s1 <= i_pin;
			pin_s2 <= pin_s1;
			sclk_s3 <= pin_s2[`ARSP_PIN_SCLK];
			sel_s1 <= ~i_cs_n & ~i_rd_n;
			sel_s2 <= sel_s1;
		end
	end

	// ==========================================================
	// Register file over AXI4-Lite
	logic [31:0] ctrl, next_ctrl;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [W-1:0] last_result;
	arsp_state_t state;
	logic [1:0] buf_cnt;

	always_comb begin
		next_ctrl = ctrl;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (i_s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = i_s_axi_wdata;
			next_w_strb = i_s_axi_wstrb;
		end
		if (bvalid && i_s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `ARSP_RESP_OKAY;
			if (aw_addr[7:2] == 6'(`ARSP_CTRL_OFS >> 2)) begin
				if (w_strb[0]) begin
					next_ctrl[7:0] = w_data[7:0];
				end
			end else if (aw_addr[7:2] != 6'(`ARSP_STATUS_OFS >> 2)
				&& aw_addr[7:2] != 6'(`ARSP_RESULT_OFS >> 2)) begin
				next_bresp = `ARSP_RESP_SLVERR;
			end
		end
		if (rvalid && i_s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (i_s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = `ARSP_RESP_OKAY;
			unique case (i_s_axi_araddr[7:2])
				6'(`ARSP_CTRL_OFS >> 2): next_rdata = ctrl;
				6'(`ARSP_STATUS_OFS >> 2): next_rdata = {28'h0000000, buf_cnt, state};
				6'(`ARSP_RESULT_OFS >> 2): next_rdata = {16'h0000, last_result};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = `ARSP_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl <= `ARSP_CTRL_RST;
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	assign o_s_axi_awready = ~aw_held;
	assign o_s_axi_wready = ~w_held;
	assign o_s_axi_bvalid = bvalid;
	assign o_s_axi_bresp = bresp;
	assign o_s_axi_arready = ~rvalid;
	assign o_s_axi_rvalid = rvalid;
	assign o_s_axi_rresp = rresp;
	assign o_s_axi_rdata = rdata;

	// ==========================================================
	// Two-entry result buffer
	logic [W-1:0] buf0, buf1, next_buf0, next_buf1;
	logic [1:0] next_buf_cnt;
	logic pop, push;
	assign o_result_ready = (buf_cnt != 2'd2);
	assign push = i_result_valid & o_result_ready;

	always_comb begin
		next_buf0 = buf0;
		next_buf1 = buf1;
		next_buf_cnt = buf_cnt;
		if (pop) begin
			next_buf0 = buf1;
			next_buf_cnt = buf_cnt - 2'd1;
		end
		if (push) begin
			if (next_buf_cnt == 2'd0) begin
				next_buf0 = i_result_data;
			end else begin
				next_buf1 = i_result_data;
			end
			next_buf_cnt = next_buf_cnt + 2'd1;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			buf0 <= '0;
			buf1 <= '0;
			buf_cnt <= 2'd0;
		end else begin
			buf0 <= next_buf0;
			buf1 <= next_buf1;
			buf_cnt <= next_buf_cnt;
		end
	end

	// ==========================================================
	// Serial engine
	logic ser_mode, slave_mode, read_during_conversion_select, inv, pol, sclk_rise, sclk_fall, act_edge, tick;
	logic [1:0] div;
	logic [W-1:0] fmt_word, sreg, next_sreg, next_last;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [1:0] qph, next_qph;
	logic [7:0] qcnt, next_qcnt, qlen;
	arsp_state_t next_state;

	assign ser_mode = ctrl[`ARSP_CTRL_SER_BIT];
	assign slave_mode = pin_s2[`ARSP_PIN_CLKSRC];
	assign read_during_conversion_select = pin_s2[`ARSP_PIN_RDC];
	assign inv = pin_s2[`ARSP_PIN_INV];
	assign pol = pin_s2[`ARSP_PIN_POL];
	assign div = pin_s2[`ARSP_PIN_DIV_LO +: 2];
	assign fmt_word = {buf0[W-1] ^ ctrl[`ARSP_CTRL_FMT_BIT], buf0[W-2:0]};
	assign sclk_rise = pin_s2[`ARSP_PIN_SCLK] & ~sclk_s3;
	assign sclk_fall = ~pin_s2[`ARSP_PIN_SCLK] & sclk_s3;
	assign act_edge = inv ? sclk_fall : sclk_rise;
	assign qlen = read_during_conversion_select ? 8'(`ARSP_QTR_RDC_CYC) : 8'(8'(`ARSP_QTR_RAC_CYC) << div);
	assign tick = (qcnt == qlen - 8'd1);

	always_comb begin
		next_state = state;
		next_sreg = sreg;
		next_bit_cnt = bit_cnt;
		next_qph = qph;
		next_qcnt = qcnt;
		next_last = last_result;
		pop = 1'b0;
		unique case (state)
			ARSP_IDLE: begin
				if (!ser_mode && buf_cnt != 2'd0) begin
					pop = 1'b1;
					next_last = fmt_word;
				end else if (ser_mode && slave_mode && sel_s2) begin
					next_state = ARSP_SLAVE;
					if (buf_cnt != 2'd0) begin
						pop = 1'b1;
						next_sreg = fmt_word;
						next_last = fmt_word;
					end
				end else if (ser_mode && !slave_mode && buf_cnt != 2'd0
					&& (read_during_conversion_select || !i_conv_busy)) begin
					pop = 1'b1;
					next_state = ARSP_MASTER;
					next_sreg = fmt_word;
					next_last = fmt_word;
					next_bit_cnt = 5'(`ARSP_RESULT_BITS);
					next_qph = 2'd0;
					next_qcnt = 8'd0;
				end
			end
			ARSP_MASTER: begin
				next_qcnt = tick ? 8'd0 : qcnt + 8'd1;
				if (tick) begin
					next_qph = qph + 2'd1;
					if (qph == 2'd3) begin
						next_bit_cnt = bit_cnt - 5'd1;
						next_sreg = {sreg[W-2:0], 1'b0};
						if (bit_cnt == 5'd1) begin
							next_state = ARSP_IDLE;
						end
					end
				end
			end
			ARSP_SLAVE: begin
				if (!sel_s2 || !slave_mode || !ser_mode) begin
					next_state = ARSP_IDLE;
				end else if (act_edge) begin
					next_sreg = {sreg[W-2:0], pin_s2[`ARSP_PIN_RDC]};
				end
			end
			default: next_state = ARSP_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ARSP_IDLE;
			sreg <= '0;
			bit_cnt <= 5'd0;
			qph <= 2'd0;
			qcnt <= 8'd0;
			last_result <= '0;
		end else begin
			state <= next_state;
			sreg <= next_sreg;
			bit_cnt <= next_bit_cnt;
			qph <= next_qph;
			qcnt <= next_qcnt;
			last_result <= next_last;
		end
	end

	// ==========================================================
	// Shared pin drive
	logic frame_on, sclk_int;
	assign frame_on = (state == ARSP_MASTER);
	assign sclk_int = ((qph == 2'd1) || (qph == 2'd2)) & frame_on;

	always_comb begin
		if (!ser_mode) begin
			o_pin = last_result;
			o_pin_oe = {W{1'b1}};
		end else begin
			o_pin = {last_result[W-1:11], 9'h000, last_result[1:0]};
			o_pin_oe = {{(W-11){1'b1}}, 9'h000, 2'b11};
			o_pin[`ARSP_PIN_SDO] = sreg[W-1];
			o_pin_oe[`ARSP_PIN_SDO] = 1'b1;
			o_pin[`ARSP_PIN_FRAME] = !slave_mode & (frame_on ^ pol);
			o_pin_oe[`ARSP_PIN_FRAME] = 1'b1;
			o_pin[`ARSP_PIN_SCLK] = sclk_int ^ inv;
			o_pin_oe[`ARSP_PIN_SCLK] = !slave_mode;
		end
	end
endmodule : arsp_port

// ### test/arsp_port_assertions.sv
// Checker of the result port pins and read channel
`timescale 1ns/1ps
module arsp_port_assertions #(
	parameter int W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic i_cs_n,
	input wire logic [W-1:0] i_pin,
	input wire logic [W-1:0] o_pin,
	input wire logic [W-1:0] o_pin_oe
);
	// ==========
	// Pin mirror
	logic [W-1:0] p1;
	logic [W-1:0] ps;
	logic [2:0] cs;
	logic x_d;
	logic mclk_d;
	logic [4:0] bits;
	logic [3:0] since;
	wire ser = !o_pin_oe[7];
	wire mst = ser && !ps[4];
	wire slv = ser && ps[4];
	wire fa = o_pin[10] ^ ps[5];
	wire mclk = o_pin[9] ^ ps[6];
	wire x = ps[9] ^ ps[6];
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			p1 <= '0;
			ps <= '0;
			cs <= '1;
			x_d <= 1'h0;
			mclk_d <= 1'h0;
			bits <= '0;
			since <= '0;
		end else begin
			p1 <= i_pin;
			ps <= p1;
			cs <= {cs[1:0], i_cs_n};
			x_d <= x;
			mclk_d <= mclk;
			bits <= !fa ? 5'h0 : bits + {4'h0, mclk && !mclk_d};
			since <= ((x && !x_d) || cs[1] != cs[2]) ? 4'h0 : since + {3'h0, since != 4'hF};
		end
	end
	// ==========
	// Properties
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_sdo_stable_edges: assert property (
		mst && $past(mst) && $changed(o_pin[9]) |-> $stable(o_pin[8]))
		else $error("serial out moved on a master clock edge");
	a_slave_edge_only: assert property (
		slv && $past(slv) && $changed(o_pin[8]) |-> since <= 4'h4)
		else $error("serial out moved away from an active edge");
	a_frame_sixteen: assert property (
		mst && $past(mst) && $past(mst, 3) && $fell(fa) |-> bits == 5'h10)
		else $error("frame did not carry sixteen clocks");
	a_div_pins_hiz: assert property (ser |-> o_pin_oe[3:2] == 2'h0)
		else $error("divider pins driven in serial mode");
	a_par_all_driven: assert property (o_pin_oe[7] |-> &o_pin_oe)
		else $error("parallel bus not fully driven");
	a_slave_clk_in: assert property (
		slv && $past(slv) && $past(slv, 2) |-> !o_pin_oe[9])
		else $error("shift clock driven in slave mode");
	a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read data not answered");
	a_rdata_hold: assert property (
		o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data not held");
endmodule : arsp_port_assertions
bind arsp_port arsp_port_assertions #(.W(W)) chk (
	.i_ref_clk, .i_rst, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
	.o_s_axi_rvalid, .i_s_axi_rready, .i_cs_n, .i_pin, .o_pin, .o_pin_oe);

// ### test/arsp_host_model.sv
// Host side model reading the serial result link
`timescale 1ns/1ps
module arsp_host_model (
	input wire logic i_ref_clk,
	input wire logic i_sdo,
	input wire logic i_mclk,
	input wire logic i_frame_act,
	output logic o_cs_n,
	output logic o_sclk,
	output logic [31:0] o_word,
	output logic [5:0] o_cnt
);
	initial begin
		o_cs_n = 1'h1;
		o_sclk = 1'h0;
	end
	// ==========
	// Master frame sampling
	always @(posedge i_mclk) begin
		if (i_frame_act) begin
			o_word <= {o_word[30:0], i_sdo};
			o_cnt <= o_cnt + 6'h1;
		end
	end
	task automatic clear();
		o_word <= '0;
		o_cnt <= '0;
	endtask : clear
	// ==========
	// Slave read with gated clock
	task automatic slave_read(input logic inv, input int n);
		o_sclk <= inv;
		repeat (4) @(posedge i_ref_clk);
		o_cs_n <= 1'h0;
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge i_ref_clk);
			o_word <= {o_word[30:0], i_sdo};
			o_sclk <= inv;
			repeat (8) @(posedge i_ref_clk);
			o_sclk <= !inv;
		end
		repeat (8) @(posedge i_ref_clk);
		o_sclk <= inv;
		o_cs_n <= 1'h1;
	endtask : slave_read
endmodule : arsp_host_model

// ### test/arsp_port_tb.sv
// Testbench of the result port
`timescale 1ns/1ps
`include "arsp_regs.svh"
module arsp_port_tb;
	logic i_ref_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [7:0] i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
	logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0, i_result_valid = 1'h0;
	logic i_conv_busy = 1'h0;
	logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, word;
	logic [3:0] i_s_axi_wstrb = 4'hF;
	logic [15:0] i_result_data = 16'h0, pins = 16'h0, i_pin, o_pin, o_pin_oe;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
	logic o_s_axi_rvalid, o_result_ready, i_cs_n, sclk;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic [5:0] cnt;
	int n_errors = 0, check_count = 0;
	always #25 i_ref_clk = ~i_ref_clk;
	assign i_pin = {pins[15:10], sclk, pins[8:0]};
	wire fr = ~o_pin_oe[7] & ~pins[4] & (o_pin[10] ^ pins[5]);
	arsp_port dut (.i_ref_clk, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
		.o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
		.o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_result_data,
		.i_result_valid, .o_result_ready, .i_conv_busy, .i_cs_n, .i_rd_n(i_cs_n), .i_pin,
		.o_pin, .o_pin_oe);
	arsp_host_model host (.i_ref_clk, .i_sdo(o_pin[8]), .i_mclk(o_pin[9]), .i_frame_act(fr),
		.o_cs_n(i_cs_n), .o_sclk(sclk), .o_word(word), .o_cnt(cnt));
	// ==========
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge i_ref_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		tb = 1'h0;
		for (int i = 0; i < 50 && !tb; i++) begin
			@(negedge i_ref_clk);
			ta = o_s_axi_awready;
			tw = o_s_axi_wready;
			tb = o_s_axi_bvalid;
			if (tb) check({30'h0, o_s_axi_bresp}, {30'h0, `ARSP_RESP_OKAY});
			@(posedge i_ref_clk);
			if (ta) i_s_axi_awvalid <= 1'h0;
			if (tw) i_s_axi_wvalid <= 1'h0;
		end
		i_s_axi_bready <= 1'h0;
		check(tb, 1);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		@(posedge i_ref_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		tr = 1'h0;
		for (int i = 0; i < 50 && !tr; i++) begin
			@(negedge i_ref_clk);
			ta = o_s_axi_arready;
			tr = o_s_axi_rvalid;
			if (tr) check({o_s_axi_rresp, o_s_axi_rdata}, {er, ed});
			@(posedge i_ref_clk);
			if (ta) i_s_axi_arvalid <= 1'h0;
		end
		i_s_axi_rready <= 1'h0;
		check(tr, 1);
	endtask : axr
	task automatic push(input logic [15:0] d);
		@(posedge i_ref_clk);
		i_result_data <= d;
		i_result_valid <= 1'h1;
		do @(negedge i_ref_clk); while (o_result_ready !== 1'h1);
		@(posedge i_ref_clk);
		i_result_valid <= 1'h0;
	endtask : push
	task automatic cfg(input logic [15:0] p, input logic b);
		@(posedge i_ref_clk);
		pins <= p;
		i_conv_busy <= b;
		repeat (4) @(posedge i_ref_clk);
	endtask : cfg
	task automatic frame();
		for (int i = 0; i < 400 && !fr; i++) @(posedge i_ref_clk);
		for (int i = 0; i < 400 && fr; i++) @(posedge i_ref_clk);
	endtask : frame
	// ==========
	// Scenarios
	task automatic t_par();
		push(16'h1234);
		repeat (4) @(posedge i_ref_clk);
		check(o_pin, 16'h1234);
		check(o_pin_oe, 16'hFFFF);
		axw(`ARSP_CTRL_OFS, 32'h2);
		push(16'h1234);
		repeat (4) @(posedge i_ref_clk);
		check(o_pin, 16'h9234);
		axr(`ARSP_RESULT_OFS, 32'h9234, `ARSP_RESP_OKAY);
		axr(8'h0C, 32'h0, `ARSP_RESP_SLVERR);
		$display("parallel test done");
	endtask : t_par
	task automatic t_mst();
		axw(`ARSP_CTRL_OFS, 32'h1);
		axr(`ARSP_CTRL_OFS, 32'h1, `ARSP_RESP_OKAY);
		cfg(16'h0004, 1'h1);
		push(16'hA5C3);
		repeat (40) @(posedge i_ref_clk);
		check(fr, 0);
		host.clear();
		cfg(16'h0004, 1'h0);
		frame();
		check(word[15:0], 16'hA5C3);
		check(cnt, 16);
		$display("master test done");
	endtask : t_mst
	task automatic t_slv();
		cfg(16'h0090, 1'h0);
		push(16'h8001);
		push(16'h7E5A);
		repeat (2) @(posedge i_ref_clk);
		check(o_result_ready, 0);
		axr(`ARSP_STATUS_OFS, 32'h8, `ARSP_RESP_OKAY);
		host.slave_read(1'h0, 32);
		check(word, 32'h8001FFFF);
		cfg(16'h0070, 1'h0);
		host.slave_read(1'h1, 32);
		check(word, 32'h7E5A0000);
		check(o_result_ready, 1);
		$display("slave test done");
	endtask : t_slv
	task automatic t_rdc();
		cfg(16'h00E4, 1'h1);
		host.clear();
		push(16'h3C96);
		frame();
		check(word[15:0], 16'h3C96);
		check(cnt, 16);
		$display("read during convert test done");
	endtask : t_rdc
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'h0;
		t_par();
		t_mst();
		t_slv();
		t_rdc();
		stop_test();
	end
	initial begin
		#500000;
		n_errors++;
		stop_test();
	end
endmodule : arsp_port_tb
